// ### pkg/bpwd_pkg.sv
// Constants and types for the pattern word decoder.
// Assumes a single 125 MHz clock domain.
package bpwd_pkg;

  typedef enum logic [1:0] {
    BPWD_BIT,
    BPWD_8B10B,
    BPWD_128B130B
  } bpwd_mode_t;

  localparam int WORD_W = 144;
  localparam int DATA_W = 128;
  localparam int LFSR_W = 16;
  localparam int ADR_W  = 8;

  // Register byte addresses
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_LFSR  = 8'h04;
  localparam logic [7:0] OFS_CMPN  = 8'h08;
  localparam logic [7:0] OFS_MSKN  = 8'h0c;
  localparam logic [7:0] OFS_STAT  = 8'h10;

  // Control field positions
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_MASK_EN = 2;
  localparam int CTRL_SQL_EN  = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Plain bit coding
  localparam int BIT_DATA  = 0;
  localparam int BIT_ATTR1 = 1;
  localparam int BIT_SQL2  = 2;

  // 8b/10b word
  localparam int K8_DATA_HI = 7;
  localparam int K8_KCHAR   = 8;
  localparam int K8_RSVD    = 9;
  localparam int K8_MASK    = 10;
  localparam int K8_SQL     = 11;
  localparam int K8_SCR_EN  = 12;
  localparam int K8_SCR_PS  = 13;
  localparam int K8_SCR_RST = 14;
  localparam int K8_SOF     = 15;

  // 128b/130b word
  localparam int W1_FRM_HI  = 1;
  localparam int W1_DATA_LO = 2;
  localparam int W1_DATA_HI = 129;
  localparam int W1_MASK    = 130;
  localparam int W1_SQL     = 131;
  localparam int W1_SCR_RST = 132;
  localparam int W1_SCR_PS  = 133;
  localparam int W1_BYP     = 134;
  localparam int W1_BYP0    = 135;
  localparam int W1_DC_DO   = 136;
  localparam int W1_DC_RST  = 137;
  localparam int W1_SEND_ST = 138;
  localparam int W1_PAR_RST = 139;
  localparam int W1_PAR_PS  = 140;
  localparam int W1_SOF     = 141;
  localparam int W1_RSVD_LO = 142;

  localparam logic [15:0] LFSR_SEED = 16'hffff;
  localparam logic [15:0] LFSR_TAPS = 16'h0039;
  localparam logic [31:0] CNT_RST   = 32'h0000_0000;

endpackage

// ### core/bpwd_decoder.sv
// Pattern word decoder: splits stored words into transmit
// and receive controls; Wishbone classic register slave.
// Assumes words arrive on the system clock, one per valid.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module bpwd_decoder (
  input  wire logic                          i_clk_sys,      // 125 MHz
  input  wire logic                          i_rst,          // Async, high
  input  wire logic                          i_wb_cyc,       // Bus cycle
  input  wire logic                          i_wb_stb,       // Strobe
  input  wire logic                          i_wb_we,        // Write
  input  wire logic [bpwd_pkg::ADR_W-1:0]    i_wb_adr,       // Byte address
  input  wire logic [31:0]                   i_wb_dat,       // Write data
  input  wire logic [3:0]                    i_wb_sel,       // Byte lanes
  output logic      [31:0]                   o_wb_dat,       // Read data
  output logic                               o_wb_ack,       // Acknowledge
  input  wire logic                          i_word_valid,   // Word strobe
  input  wire logic [bpwd_pkg::WORD_W-1:0]   i_word,         // Stored word
  output logic                               o_tx_valid,     // Tx symbol
  output logic [bpwd_pkg::DATA_W-1:0]        o_tx_data,      // Tx data
  output logic [1:0]                         o_tx_frame,     // Framing bits
  output logic                               o_tx_kchar,     // Control char
  output logic                               o_tx_squelch,   // Squelch level
  output logic                               o_tx_scr_en,    // Scramble on
  output logic                               o_tx_scr_byp,   // Bypass symbol
  output logic                               o_tx_scr_byp0,  // Bypass byte 0
  output logic [bpwd_pkg::LFSR_W-1:0]        o_tx_lfsr,      // Scrambler state
  output logic                               o_tx_dc_do,     // DC balance
  output logic                               o_tx_dc_clr,    // Clear balance
  output logic                               o_tx_send_st,   // Send state
  output logic                               o_tx_parity,    // Running parity
  output logic                               o_rx_valid,     // Rx symbol
  output logic [bpwd_pkg::DATA_W-1:0]        o_rx_data,      // Expected data
  output logic                               o_rx_kchar,     // Control char
  output logic                               o_rx_compare,   // Compare symbol
  output logic                               o_rx_sof,       // Start of frame
  output logic                               o_rx_scr_byp,   // Bypass symbol
  output logic                               o_rx_scr_byp0   // Bypass byte 0
);
  import bpwd_pkg::*;

  ////////////////////////////////////////////////////////////
  // Register bus

  logic [3:0]  ctrl_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] cmp_cnt_ff;
  logic [31:0] msk_cnt_ff;
  logic [LFSR_W-1:0] lfsr_ff;
  logic        par_ff;
  logic        rsvd_seen_ff;
  logic        bus_req;
  bpwd_mode_t  mode;
  logic        mask_en;
  logic        sql_en;

  assign bus_req  = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign mode     = bpwd_mode_t'(ctrl_ff[CTRL_MODE_LO +: 2]);
  assign mask_en  = ctrl_ff[CTRL_MASK_EN];
  assign sql_en   = ctrl_ff[CTRL_SQL_EN];
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  // Answer one cycle after the strobe, drop the cycle after
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // Mode changes take effect for the next word only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (bus_req && i_wb_we && i_wb_sel[0]
                 && i_wb_adr == OFS_CTRL) begin
      ctrl_ff <= i_wb_dat[3:0];
    end
  end

  // Unmapped addresses read as zero and still acknowledge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdat_ff <= 32'h0000_0000;
    end else if (bus_req && !i_wb_we) begin
      case (i_wb_adr)
        OFS_CTRL: rdat_ff <= {28'h000_0000, ctrl_ff};
        OFS_LFSR: rdat_ff <= {16'h0000, lfsr_ff};
        OFS_CMPN: rdat_ff <= cmp_cnt_ff;
        OFS_MSKN: rdat_ff <= msk_cnt_ff;
        OFS_STAT: rdat_ff <= {30'h0000_0000, rsvd_seen_ff, par_ff};
        default:  rdat_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdat_ff <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////
  // Word decode

  logic [DATA_W-1:0] d_data;
  logic [1:0] d_frame;
  logic d_kchar;
  logic d_mask;
  logic d_sql;
  logic d_scr_en;
  logic d_scr_ps;
  logic d_scr_rst;
  logic d_byp;
  logic d_byp0;
  logic d_dc_do;
  logic d_dc_clr;
  logic d_send;
  logic d_par_rst;
  logic d_par_ps;
  logic d_sof;
  logic d_rsvd;

  // Attribute gated by its enable; off means don't-care
  function automatic logic gate_attr(input logic en, input logic b);
    return en & b;
  endfunction

  always_comb begin
    d_data    = '0;
    d_frame   = 2'b00;
    d_kchar   = 1'b0;
    d_mask    = 1'b0;
    d_sql     = 1'b0;
    d_scr_en  = 1'b0;
    d_scr_ps  = 1'b0;
    d_scr_rst = 1'b0;
    d_byp     = 1'b0;
    d_byp0    = 1'b0;
    d_dc_do   = 1'b0;
    d_dc_clr  = 1'b0;
    d_send    = 1'b0;
    d_par_rst = 1'b0;
    d_par_ps  = 1'b0;
    d_sof     = 1'b0;
    d_rsvd    = 1'b0;
    case (mode)
      BPWD_BIT: begin
        d_data[0] = i_word[BIT_DATA];
        if (mask_en && sql_en) begin
          d_mask = i_word[BIT_ATTR1];
          d_sql  = i_word[BIT_SQL2];
        end else begin
          d_mask = gate_attr(mask_en, i_word[BIT_ATTR1]);
          d_sql  = gate_attr(sql_en, i_word[BIT_ATTR1]);
        end
      end
      BPWD_8B10B: begin
        d_data[7:0] = i_word[K8_DATA_HI:0];
        d_kchar   = i_word[K8_KCHAR];
        d_mask    = gate_attr(mask_en, i_word[K8_MASK]);
        d_sql     = gate_attr(sql_en, i_word[K8_SQL]);
        d_scr_en  = i_word[K8_SCR_EN];
        d_scr_ps  = i_word[K8_SCR_PS];
        d_scr_rst = i_word[K8_SCR_RST];
        d_sof     = i_word[K8_SOF];
        d_rsvd    = i_word[K8_RSVD];
      end
      BPWD_128B130B: begin
        d_frame   = i_word[W1_FRM_HI:0];
        d_data    = i_word[W1_DATA_HI:W1_DATA_LO];
        d_mask    = gate_attr(mask_en, i_word[W1_MASK]);
        d_sql     = gate_attr(sql_en, i_word[W1_SQL]);
        d_scr_en  = 1'b1;
        d_scr_rst = i_word[W1_SCR_RST];
        d_scr_ps  = i_word[W1_SCR_PS];
        d_byp     = i_word[W1_BYP];
        d_byp0    = i_word[W1_BYP0];
        d_dc_do   = i_word[W1_DC_DO];
        d_dc_clr  = i_word[W1_DC_RST];
        d_send    = i_word[W1_SEND_ST];
        d_par_rst = i_word[W1_PAR_RST];
        d_par_ps  = i_word[W1_PAR_PS];
        d_sof     = i_word[W1_SOF];
        d_rsvd    = |i_word[WORD_W-1:W1_RSVD_LO];
      end
      default: begin
        d_data = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // Scrambler state

  function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] s);
    return {s[LFSR_W-2:0], ^(s & LFSR_TAPS)};
  endfunction

  logic [LFSR_W-1:0] lfsr_use;
  logic [LFSR_W-1:0] nxt_lfsr;
  logic scr_active;

  // Reset applies to the symbol that carries it
  assign lfsr_use   = d_scr_rst ? LFSR_SEED : lfsr_ff;
  assign scr_active = d_scr_en & ~d_byp;
  assign nxt_lfsr   = d_scr_ps ? lfsr_use : lfsr_step(lfsr_use);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lfsr_ff <= LFSR_SEED;
    end else if (i_word_valid) begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  ////////////////////////////////////////////////////////////
  // Transmit parity

  logic par_use;

  assign par_use = d_par_rst ? 1'b0 : par_ff;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      par_ff <= 1'b0;
    end else if (i_word_valid) begin
      par_ff <= d_par_ps ? par_use : par_use ^ (^d_data);
    end
  end

  // Sticky flag: a reserved bit was seen set
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rsvd_seen_ff <= 1'b0;
    end else if (i_word_valid && d_rsvd) begin
      rsvd_seen_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Transmit path: mask and start of frame ignored here

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_tx_valid    <= 1'b0;
      o_tx_data     <= '0;
      o_tx_frame    <= 2'b00;
      o_tx_kchar    <= 1'b0;
      o_tx_squelch  <= 1'b0;
      o_tx_scr_en   <= 1'b0;
      o_tx_scr_byp  <= 1'b0;
      o_tx_scr_byp0 <= 1'b0;
      o_tx_lfsr     <= LFSR_SEED;
      o_tx_dc_do    <= 1'b0;
      o_tx_dc_clr   <= 1'b0;
      o_tx_send_st  <= 1'b0;
      o_tx_parity   <= 1'b0;
    end else begin
      o_tx_valid    <= i_word_valid;
      // Squelched symbols carry no data
      o_tx_data     <= d_sql ? '0 : d_data;
      o_tx_frame    <= d_frame;
      o_tx_kchar    <= d_kchar;
      o_tx_squelch  <= d_sql;
      o_tx_scr_en   <= scr_active;
      o_tx_scr_byp  <= d_byp;
      o_tx_scr_byp0 <= d_byp0;
      o_tx_lfsr     <= lfsr_use;
      o_tx_dc_do    <= d_dc_do;
      o_tx_dc_clr   <= d_dc_clr;
      o_tx_send_st  <= d_send;
      o_tx_parity   <= par_use;
    end
  end

  ////////////////////////////////////////////////////////////
  // Receive path: squelch and scrambler enable, pause and reset ignored here; bypass passed on

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rx_valid    <= 1'b0;
      o_rx_data     <= '0;
      o_rx_kchar    <= 1'b0;
      o_rx_compare  <= 1'b1;
      o_rx_sof      <= 1'b0;
      o_rx_scr_byp  <= 1'b0;
      o_rx_scr_byp0 <= 1'b0;
    end else begin
      o_rx_valid    <= i_word_valid;
      o_rx_data     <= d_data;
      o_rx_kchar    <= d_kchar;
      o_rx_compare  <= ~d_mask;
      o_rx_sof      <= d_sof;
      o_rx_scr_byp  <= d_byp;
      o_rx_scr_byp0 <= d_byp0;
    end
  end

  // Count compared and excluded symbols
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmp_cnt_ff <= CNT_RST;
      msk_cnt_ff <= CNT_RST;
    end else if (o_rx_valid) begin
      if (o_rx_compare) begin
        cmp_cnt_ff <= cmp_cnt_ff + 32'h0000_0001;
      end else begin
        msk_cnt_ff <= msk_cnt_ff + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks

  a_bit_mask_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode == BPWD_BIT && mask_en && !sql_en)
      |=> (o_rx_compare == !$past(i_word[1])) && !o_tx_squelch)
    else $error("bit coding mask decode wrong");

  a_bit_both_attr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode == BPWD_BIT && mask_en && sql_en)
      |=> (o_tx_squelch == $past(i_word[2]))
          && (o_rx_compare == !$past(i_word[1])))
    else $error("bit coding two attributes wrong");

  a_squelch_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_tx_squelch |-> (o_tx_data == '0))
    else $error("squelched symbol carries data");

  a_k8_fields: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode == BPWD_8B10B)
      |=> (o_tx_kchar == $past(i_word[8])) && (o_rx_sof == $past(i_word[15])))
    else $error("8b10b class or frame start wrong");

  a_mask_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && !mask_en) |=> o_rx_compare)
    else $error("disabled mask excluded a symbol");

  a_lfsr_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode == BPWD_128B130B && i_word[132])
      |=> (o_tx_lfsr == LFSR_SEED))
    else $error("scrambler reset not applied");

  a_lfsr_pause: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode != BPWD_BIT && d_scr_ps && !d_scr_rst)
      |=> $stable(lfsr_ff))
    else $error("paused scrambler advanced");

  a_w1_data: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode == BPWD_128B130B && !d_sql)
      |=> (o_rx_data == $past(i_word[W1_DATA_HI:W1_DATA_LO])) && (o_tx_data == o_rx_data)
          && (o_tx_frame == $past(i_word[1:0])))
    else $error("128b130b data or framing wrong");

  a_par_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_word_valid && mode == BPWD_128B130B && i_word[139])
      |=> !o_tx_parity)
    else $error("parity reset ignored");

  a_bus_ack: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");

endmodule
`default_nettype wire

// ### testbench/bpwd_far_side.sv
// Far-side model: serial generator and error analyzer.
// Assumes decoder outputs are registered on i_clk_sys.
`timescale 1ns/1ps
`default_nettype none

module bpwd_far_side (
  input  wire logic        i_clk_sys,    // 125 MHz
  input  wire logic        i_rst,        // Async, high
  input  wire logic        i_tx_valid,   // Tx symbol
  input  wire logic        i_tx_squelch, // Squelch request
  input  wire logic        i_rx_valid,   // Rx symbol
  input  wire logic        i_rx_compare, // Compare request
  output logic      [15:0] o_n_cmp,      // Compared symbols
  output logic      [15:0] o_n_msk,      // Masked symbols
  output logic      [15:0] o_n_sql       // Squelched symbols
);
  ////////////////////////////////////////////////////////////
  // Analyzer: only receive symbols reach the compare and mask counters
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_n_cmp <= 16'h0000;
      o_n_msk <= 16'h0000;
    end else if (i_rx_valid) begin
      if (i_rx_compare) begin
        o_n_cmp <= o_n_cmp + 16'h0001;
      end else begin
        o_n_msk <= o_n_msk + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Generator: squelched symbols go out at out-of-band level
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_n_sql <= 16'h0000;
    end else if (i_tx_valid && i_tx_squelch) begin
      o_n_sql <= o_n_sql + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// ### testbench/bpwd_decoder_bench.sv
// Bench for the pattern word decoder: bus and word-stream tests.
// Assumes the far-side model watches the decoder outputs.
`timescale 1ns/1ps
`default_nettype none

module bpwd_decoder_bench;
  import bpwd_pkg::*;
  logic          i_clk_sys, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_word_valid;
  logic [7:0]    i_wb_adr;
  logic [31:0]   i_wb_dat, o_wb_dat;
  logic [3:0]    i_wb_sel;
  logic [143:0]  i_word;
  logic          o_wb_ack, o_tx_valid, o_tx_kchar, o_tx_squelch, o_tx_scr_en;
  logic          o_tx_scr_byp, o_tx_scr_byp0, o_tx_dc_do, o_tx_dc_clr, o_tx_send_st;
  logic          o_tx_parity, o_rx_valid, o_rx_kchar, o_rx_compare, o_rx_sof;
  logic          o_rx_scr_byp, o_rx_scr_byp0;
  logic [127:0]  o_tx_data, o_rx_data;
  logic [1:0]    o_tx_frame;
  logic [15:0]   o_tx_lfsr, n_cmp, n_msk, n_sql, e_cmp, e_msk, e_sql, s1;
  logic [127:0]  dd;
  logic [2:0]    wd;
  logic          mk, sq;
  int            failures, n_compared;

  bpwd_decoder i_dut (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
    .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_word_valid, .i_word, .o_tx_valid, .o_tx_data,
    .o_tx_frame, .o_tx_kchar, .o_tx_squelch, .o_tx_scr_en, .o_tx_scr_byp, .o_tx_scr_byp0,
    .o_tx_lfsr, .o_tx_dc_do, .o_tx_dc_clr, .o_tx_send_st, .o_tx_parity, .o_rx_valid,
    .o_rx_data, .o_rx_kchar, .o_rx_compare, .o_rx_sof, .o_rx_scr_byp, .o_rx_scr_byp0);

  bpwd_far_side u_far (.i_clk_sys, .i_rst, .i_tx_valid(o_tx_valid), .i_tx_squelch(o_tx_squelch),
    .i_rx_valid(o_rx_valid), .i_rx_compare(o_rx_compare), .o_n_cmp(n_cmp), .o_n_msk(n_msk),
    .o_n_sql(n_sql));

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Wide enough for a flag packed above a full data word
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; the slave's latency is not assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] got;
    int          n;
    got = 32'h0;
    @(posedge i_clk_sys);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    for (n = 0; n < 16; n++) begin
      @(posedge i_clk_sys);
      if (o_wb_ack === 1'b1) begin
        got = o_wb_dat;
        break;
      end
    end
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    if (n == 16) begin
      failures++;
      end_of_test();
    end else begin
      chk(got & m, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, 32'h0, 32'h0);
    // Read back so the write itself is checked
    bus(1'b0, a, 32'h0, 4'hf, d & 32'h0000000f, 32'h0000000f);
  endtask

  task automatic put(input logic [143:0] w);
    @(posedge i_clk_sys);
    i_word_valid <= 1'b1;
    i_word       <= w;
    @(posedge i_clk_sys);
    i_word_valid <= 1'b0;
    #1;
    chk({o_tx_valid, o_rx_valid}, 2'b11);
  endtask

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], ^(s & LFSR_TAPS)};
  endfunction

  // 128b/130b word with framing 2'b10 and attribute bit b set when b is 130 or above
  function automatic logic [143:0] w1(input int b, input logic [127:0] d);
    logic [143:0] w;
    w        = 144'h0;
    w[129:2] = d;
    w[1:0]   = 2'b10;
    if (b >= 130) w[b] = 1'b1;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////
  initial begin
    {i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_word_valid} = 5'b10000;
    {i_wb_adr, i_wb_dat, i_wb_sel, i_word} = '0;
    {failures, n_compared, e_cmp, e_msk, e_sql} = '0;
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0, 4'hf, 32'h0, 32'hffffffff);
    bus(1'b0, OFS_LFSR, 32'h0, 4'hf, {16'h0, LFSR_SEED}, 32'hffffffff);
    bus(1'b0, OFS_STAT, 32'h0, 4'hf, 32'h0, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0, 4'hf, 32'h0, 32'hffffffff);
    bus(1'b1, OFS_CTRL, 32'h0000000e, 4'h0, 32'h0, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0, 4'hf, 32'h0, 32'hffffffff);
    $display("test registers done");

    // Bit coding: every enable combination, every 3-bit word
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL, {28'h0, c[1:0], 2'b00});
      for (int w = 0; w < 8; w++) begin
        wd = w[2:0];
        mk = c[0] & wd[1];
        sq = c[1] & (c[0] ? wd[2] : wd[1]);
        put({141'h0, wd});
        chk({o_tx_squelch, o_tx_data}, {sq, 127'h0, wd[0] & !sq});
        chk({o_rx_compare, o_rx_data}, {!mk, 127'h0, wd[0]});
        e_cmp += {15'h0, !mk};
        e_msk += {15'h0, mk};
        e_sql += {15'h0, sq};
      end
    end
    // Far side counts the last symbol one edge later
    @(posedge i_clk_sys);
    #1;
    chk({n_cmp, n_msk, n_sql}, {e_cmp, e_msk, e_sql});
    bus(1'b0, OFS_CMPN, 32'h0, 4'hf, {16'h0, e_cmp}, 32'hffffffff);
    bus(1'b0, OFS_MSKN, 32'h0, 4'hf, {16'h0, e_msk}, 32'hffffffff);
    $display("test bit coding done");

    // 8b/10b
    wr(OFS_CTRL, 32'h0000000d);
    put(144'h95a5);
    chk({o_tx_data[7:0], o_tx_kchar, o_rx_kchar, o_rx_compare, o_tx_squelch, o_tx_scr_en, o_rx_sof},
        {8'ha5, 6'b110011});
    put(144'h083c);
    chk({o_tx_squelch, o_tx_kchar, o_tx_scr_en, o_rx_sof, o_tx_data}, {4'b1000, 128'h0});
    chk({o_rx_compare, o_rx_data}, {1'b1, 128'h3c});
    wr(OFS_CTRL, 32'h00000001);
    put(144'h0c3c);
    chk({o_tx_squelch, o_rx_compare, o_tx_data}, {2'b01, 128'h3c});
    s1 = step(LFSR_SEED);
    put(144'h4000);
    chk(o_tx_lfsr, LFSR_SEED);
    put(144'h2000);
    chk(o_tx_lfsr, s1);
    put(144'h0);
    chk(o_tx_lfsr, s1);
    put(144'h0);
    chk(o_tx_lfsr, step(s1));
    put(144'h6000);
    chk(o_tx_lfsr, LFSR_SEED);
    put(144'h0);
    chk(o_tx_lfsr, LFSR_SEED);
    put(144'h0200);
    bus(1'b0, OFS_STAT, 32'h0, 4'hf, 32'h2, 32'h2);
    $display("test 8b10b done");

    // 128b/130b: each attribute bit alone
    wr(OFS_CTRL, 32'h0000000e);
    dd = 128'h0123456789abcdef_fedcba9876543210;
    for (int b = 130; b < 142; b++) begin
      put(w1(b, dd));
      chk({o_rx_sof, 2'b00, o_tx_send_st, o_tx_dc_clr, o_tx_dc_do, o_tx_scr_byp0 & o_rx_scr_byp0,
           o_tx_scr_byp & o_rx_scr_byp & !o_tx_scr_en, 2'b00, o_tx_squelch, !o_rx_compare},
          12'b1001_1111_0011 & (12'h001 << (b - 130)));
      chk({o_tx_frame, o_rx_data}, {2'b10, dd});
      chk(o_tx_data, (b == 131) ? 128'h0 : dd);
    end
    put(w1(139, 128'h1));
    chk(o_tx_parity, 1'b0);
    put(w1(0, 128'h1));
    chk(o_tx_parity, 1'b1);
    put(w1(140, 128'h1));
    chk(o_tx_parity, 1'b0);
    put(w1(0, 128'h1));
    chk(o_tx_parity, 1'b0);
    put(w1(132, 128'h1));
    chk(o_tx_lfsr, LFSR_SEED);
    put(w1(133, 128'h1));
    chk(o_tx_lfsr, s1);
    put(w1(0, 128'h1));
    chk(o_tx_lfsr, s1);
    $display("test 128b130b done");
    end_of_test();
  end
endmodule

`default_nettype wire
